// file: rtl/gfw_map.svh
`ifndef GFW_MAP_SVH
`define GFW_MAP_SVH

`define GFW_CFG_ADDR      16'hA02E
`define GFW_ADDR_W        16
`define GFW_DATA_W        8
`define GFW_CFG_RESET     8'h00
`define GFW_RISE_BIT      7
`define GFW_FALL_BIT      6
`define GFW_FILT_LSB      4
`define GFW_FILT_W        2
`define GFW_SEL_LSB       0
`define GFW_SEL_W         4
`define GFW_PIN_CNT       16
`define GFW_CLK_HZ        200_000_000
`define GFW_FILT_BASE_MS  1
`define GFW_FILT_BASE_CYC (`GFW_CLK_HZ / 1000 * `GFW_FILT_BASE_MS)
`define GFW_FILT_MAX_SHL  3
`define GFW_CNT_W         21

`endif

// file: rtl/gfw_pkg.sv
`include "gfw_map.svh"
`default_nettype none
package gfw_pkg;
    typedef struct packed {
        logic                   rise_en;
        logic                   fall_en;
        logic [`GFW_FILT_W-1:0] filt;
        logic [`GFW_SEL_W-1:0]  sel;
    } gfw_cfg_type;

    typedef struct packed {
        logic [`GFW_PIN_CNT-1:0] s1;
        logic [`GFW_PIN_CNT-1:0] s2;
    } gfw_sync_state_type;

    typedef struct packed {
        logic                  level;
        logic [`GFW_CNT_W-1:0] cnt;
        logic                  rise;
        logic                  fall;
    } gfw_filt_state_type;

    typedef struct packed {
        gfw_cfg_type            cfg;
        logic                   rise_flag;
        logic                   fall_flag;
        logic [`GFW_DATA_W-1:0] rdata;
        logic                   wake_req;
        logic                   int_out;
        logic                   restart;
    } gfw_top_state_type;
endpackage
`default_nettype wire

// file: rtl/gfw_filt_if.sv
`include "gfw_map.svh"
`default_nettype none
interface gfw_filt_if;
    logic                   sample;
    logic                   restart;
    logic [`GFW_FILT_W-1:0] time_code;
    logic                   rise_evt;
    logic                   fall_evt;
    logic                   level;

    modport ctrl (output sample, output restart, output time_code,
                  input rise_evt, input fall_evt, input level);
    modport filt (input sample, input restart, input time_code,
                  output rise_evt, output fall_evt, output level);
endinterface
`default_nettype wire

// file: rtl/gfw_sync.sv
`include "gfw_map.svh"
`default_nettype none
module gfw_sync (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [`GFW_PIN_CNT-1:0] pin_in,
    output var  logic [`GFW_PIN_CNT-1:0] pin_sync
);
    import gfw_pkg::*;

    gfw_sync_state_type st_r;
    gfw_sync_state_type st_nxt;

    // first stage feeds only the second
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.s2;

    AST_SYNC_TWO_STAGE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ13]
        $past(rst, 2) == 1'b0 |-> pin_sync == $past(pin_in, 2))
        else $error("sync output is not input delayed by two");
endmodule
`default_nettype wire

// file: rtl/gfw_filter.sv
`include "gfw_map.svh"
`default_nettype none
module gfw_filter #(
    parameter int unsigned BASE_CYC = `GFW_FILT_BASE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    gfw_filt_if.filt  fi
);
    import gfw_pkg::*;

    localparam int CW = `GFW_CNT_W;

    initial begin
        if (BASE_CYC < 1 || (64'(BASE_CYC) << `GFW_FILT_MAX_SHL) > (64'd1 << CW)) begin
            $error("gfw_filter: BASE_CYC out of range");
        end
    end

    gfw_filt_state_type st_r;
    gfw_filt_state_type st_nxt;
    logic [CW-1:0]      limit;

    // 1, 2, 4 or 8 base periods
    assign limit = CW'(BASE_CYC) << fi.time_code; // [RQ10]

    // a new level must hold for limit samples before it is taken
    always_comb begin
        st_nxt      = st_r;
        st_nxt.rise = 1'b0;
        st_nxt.fall = 1'b0;
        if (fi.restart) begin
            st_nxt.level = fi.sample;
            st_nxt.cnt   = '0;
        end else if (fi.sample != st_r.level) begin // [RQ3]
            if (st_r.cnt >= limit - CW'(1)) begin // [RQ4]
                st_nxt.level = fi.sample;
                st_nxt.cnt   = '0;
                st_nxt.rise  = fi.sample;
                st_nxt.fall  = ~fi.sample;
            end else begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end else begin
            st_nxt.cnt = '0; // [RQ4]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fi.rise_evt = st_r.rise;
    assign fi.fall_evt = st_r.fall;
    assign fi.level    = st_r.level;

    AST_FILT_CNT_BOUND: assert property (@(posedge clk_sys) disable iff (rst) // [RQ10]
        st_r.cnt < limit)
        else $error("filter counter passed its limit");

    AST_FILT_EVT_NEEDS_RUN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
        (st_r.rise || st_r.fall) |-> $past(st_r.cnt) >= $past(limit) - CW'(1))
        else $error("filter event without a full stable run");
endmodule
`default_nettype wire

// file: rtl/gfw_top.sv
// Function
// [RQ1] selected pin change wakes sleeping CPU
// [RQ2] enabled edge interrupt also wakes, interrupts
// [RQ3] trigger on rising, falling or both
// [RQ4] pulses shorter than filter time discarded
// [RQ5] exactly one of sixteen pins feeds filter
// [RQ6] bit 7 write enables rising wake
// [RQ7] sticky rise flag, cleared writing enable zero
// [RQ8] bit 6 write enables falling wake
// [RQ9] sticky fall flag, cleared writing enable zero
// [RQ10] filter code selects 1, 2, 4, 8 ms
// [RQ11] select codes map port0 then port1 bits
// [RQ12] config register resets to all zeros
// [RQ13] selected pin synchronised before edge detection
`include "gfw_map.svh"
`default_nettype none
module gfw_top #(
    parameter int unsigned FILT_BASE_CYC = `GFW_FILT_BASE_CYC
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [`GFW_ADDR_W-1:0] reg_addr,
    input  wire logic [`GFW_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  logic [`GFW_DATA_W-1:0] reg_rdata,
    input  wire logic [7:0]             pin_port0,
    input  wire logic [7:0]             pin_port1,
    input  wire logic                   cpu_sleep,
    input  wire logic                   edge_int_req,
    output var  logic                   cpu_wake_req,
    output var  logic                   edge_int_out,
    output var  logic                   rise_wake_flag,
    output var  logic                   fall_wake_flag
);
    import gfw_pkg::*;

    initial begin
        if (FILT_BASE_CYC < 1) begin
            $error("gfw_top: FILT_BASE_CYC must be at least one");
        end
    end

    gfw_top_state_type       st_r;
    gfw_top_state_type       st_nxt;
    logic [`GFW_PIN_CNT-1:0] pin_sync;
    logic                    cfg_hit;
    logic                    wr_hit;
    logic                    rd_hit;
    logic                    rise_hit;
    logic                    fall_hit;
    logic                    wake_evt;
    logic [`GFW_SEL_W-1:0]   new_sel;

    gfw_filt_if fi ();

    // port 1 in the upper half so select code msb picks the port
    gfw_sync u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   ({pin_port1, pin_port0}), // [RQ11]
        .pin_sync (pin_sync)                // [RQ13]
    );

    gfw_filter #(
        .BASE_CYC (FILT_BASE_CYC)
    ) u_filter (
        .clk_sys (clk_sys),
        .rst     (rst),
        .fi      (fi)
    );

    // single source into the filter
    assign fi.sample    = pin_sync[st_r.cfg.sel]; // [RQ5]
    assign fi.restart   = st_r.restart;
    assign fi.time_code = st_r.cfg.filt; // [RQ10]

    // register decode
    assign cfg_hit = (reg_addr == `GFW_CFG_ADDR);
    assign wr_hit  = reg_wr && cfg_hit;
    assign rd_hit  = reg_rd && cfg_hit;
    assign new_sel = reg_wdata[`GFW_SEL_LSB +: `GFW_SEL_W];

    // qualified filtered events
    assign rise_hit = fi.rise_evt && st_r.cfg.rise_en; // [RQ3]
    assign fall_hit = fi.fall_evt && st_r.cfg.fall_en; // [RQ3]
    assign wake_evt = rise_hit || fall_hit || edge_int_req; // [RQ2]

    always_comb begin
        st_nxt         = st_r;
        st_nxt.restart = 1'b0;

        // configuration write
        if (wr_hit) begin
            st_nxt.cfg.rise_en = reg_wdata[`GFW_RISE_BIT]; // [RQ6]
            st_nxt.cfg.fall_en = reg_wdata[`GFW_FALL_BIT]; // [RQ8]
            st_nxt.cfg.filt    = reg_wdata[`GFW_FILT_LSB +: `GFW_FILT_W]; // [RQ10]
            st_nxt.cfg.sel     = new_sel; // [RQ11]
            // new pin: take its level without an event
            st_nxt.restart     = (new_sel != st_r.cfg.sel); // [RQ5]
        end

        // sticky flags: event wins over a clearing write
        if (wr_hit && !reg_wdata[`GFW_RISE_BIT]) begin
            st_nxt.rise_flag = 1'b0; // [RQ7]
        end
        if (rise_hit) begin
            st_nxt.rise_flag = 1'b1; // [RQ7]
        end
        if (wr_hit && !reg_wdata[`GFW_FALL_BIT]) begin
            st_nxt.fall_flag = 1'b0; // [RQ9]
        end
        if (fall_hit) begin
            st_nxt.fall_flag = 1'b1; // [RQ9]
        end

        // wake held until the CPU leaves sleep
        st_nxt.wake_req = (st_r.wake_req || wake_evt) && cpu_sleep; // [RQ1]
        st_nxt.int_out  = edge_int_req; // [RQ2]

        // read data valid only the cycle after the strobe
        if (rd_hit) begin
            st_nxt.rdata = {st_r.rise_flag, st_r.fall_flag, st_r.cfg.filt, st_r.cfg.sel}; // [RQ7]
        end else begin
            st_nxt.rdata = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r     <= '0;
            st_r.cfg <= gfw_cfg_type'(`GFW_CFG_RESET); // [RQ12]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata      = st_r.rdata;
    assign cpu_wake_req   = st_r.wake_req;
    assign edge_int_out   = st_r.int_out;
    assign rise_wake_flag = st_r.rise_flag;
    assign fall_wake_flag = st_r.fall_flag;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_WAKE_ON_FILTERED: assert property ( // [RQ1]
        (rise_hit || fall_hit) && cpu_sleep |=> cpu_wake_req)
        else $error("filtered event did not wake the CPU");

    AST_WAKE_HOLDS: assert property ( // [RQ1]
        cpu_wake_req && cpu_sleep |=> cpu_wake_req)
        else $error("wake request dropped while CPU sleeps");

    AST_EDGE_WAKE_AND_INT: assert property ( // [RQ2]
        edge_int_req && cpu_sleep |=> cpu_wake_req && edge_int_out)
        else $error("edge interrupt did not wake and interrupt together");

    AST_WAKE_HAS_CAUSE: assert property ( // [RQ3]
        $rose(cpu_wake_req) |-> $past(rise_hit || fall_hit || edge_int_req))
        else $error("wake request without an enabled cause");

    AST_RISE_FLAG_SET: assert property ( // [RQ7]
        rise_hit |=> rise_wake_flag)
        else $error("rise flag not set by rising trigger");

    AST_FALL_FLAG_SET: assert property ( // [RQ9]
        fall_hit |=> fall_wake_flag)
        else $error("fall flag not set by falling trigger");

    AST_RISE_FLAG_CLEAR: assert property ( // [RQ6]
        wr_hit && !reg_wdata[`GFW_RISE_BIT] && !rise_hit |=> !rise_wake_flag)
        else $error("rise flag not cleared by enable write of zero");

    AST_FALL_FLAG_CLEAR: assert property ( // [RQ8]
        wr_hit && !reg_wdata[`GFW_FALL_BIT] && !fall_hit |=> !fall_wake_flag)
        else $error("fall flag not cleared by enable write of zero");

    AST_FLAG_STICKY: assert property ( // [RQ7]
        rise_wake_flag && !wr_hit |=> rise_wake_flag)
        else $error("rise flag lost without a write");

    AST_RESET_VALUE: assert property ( // [RQ12]
        $fell(rst) |-> st_r.cfg == gfw_cfg_type'(`GFW_CFG_RESET))
        else $error("config not zero after reset");

    AST_READ_BACK: assert property ( // [RQ6]
        rd_hit |=> reg_rdata == {$past(rise_wake_flag), $past(fall_wake_flag),
                                 $past(st_r.cfg.filt), $past(st_r.cfg.sel)})
        else $error("read data does not match flags and fields");

    AST_READ_IDLE_ZERO: assert property (
        !rd_hit |=> reg_rdata == '0)
        else $error("read data not zero outside a read");

    AST_WRITE_TAKES: assert property ( // [RQ11]
        wr_hit |=> st_r.cfg.sel == $past(new_sel) && st_r.cfg.filt == $past(reg_wdata[5:4]))
        else $error("config write not taken");

    AST_SOURCE_MUX: assert property ( // [RQ5]
        fi.restart |=> fi.level == $past(pin_sync[st_r.cfg.sel]))
        else $error("filter not loaded from the selected pin");

    AST_DISABLED_NO_FLAG: assert property ( // [RQ3]
        !st_r.cfg.rise_en && !rise_wake_flag && !wr_hit |=> !rise_wake_flag)
        else $error("rise flag set while rising wake disabled");

    COV_RISE_WAKE: cover property (rise_hit && cpu_sleep ##1 cpu_wake_req);
    COV_FALL_WAKE: cover property (fall_hit ##1 fall_wake_flag);
    COV_EDGE_WAKE: cover property (edge_int_req && cpu_sleep ##1 edge_int_out);
    COV_SET_BEATS_CLEAR: cover property (rise_hit && wr_hit && !reg_wdata[`GFW_RISE_BIT]);
endmodule
`default_nettype wire

// file: test/gfw_pin_src.sv
`default_nettype none
module gfw_pin_src (
    input  wire logic       clk_sys,
    output var  logic [7:0] pin_port0,
    output var  logic [7:0] pin_port1
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pins = 16'h0000;
    assign pin_port0 = pins[7:0];
    assign pin_port1 = pins[15:8];
    // one pin to a level, right after an edge
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_sys);
        pins[idx] <= lvl;
    endtask
    // level held for cyc cycles, then back
    task automatic pulse(input int idx, input logic lvl, input int cyc);
        set_pin(idx, lvl);
        repeat (cyc) @(posedge clk_sys);
        pins[idx] <= ~lvl;
    endtask
endmodule
`default_nettype wire

// file: test/gfw_filtered_wakeup_bench.sv
`include "gfw_map.svh"
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module gfw_filtered_wakeup_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned BASE = 4;
    logic                   clk_sys      = 1'b0;
    logic                   rst          = 1'b1;
    logic [`GFW_ADDR_W-1:0] reg_addr     = '0;
    logic [`GFW_DATA_W-1:0] reg_wdata    = '0;
    logic                   reg_wr       = 1'b0;
    logic                   reg_rd       = 1'b0;
    logic                   cpu_sleep    = 1'b0;
    logic                   edge_int_req = 1'b0;
    logic [`GFW_DATA_W-1:0] reg_rdata;
    logic [7:0]             pin_port0;
    logic [7:0]             pin_port1;
    logic                   cpu_wake_req;
    logic                   edge_int_out;
    logic                   rise_wake_flag;
    logic                   fall_wake_flag;
    logic [1:0]             en;
    logic [1:0]             code;
    int                     n;
    int                     error_cnt    = 0;
    int                     check_count  = 0;

    always #2.5 clk_sys = ~clk_sys;

    gfw_top #(.FILT_BASE_CYC(BASE)) u_dut (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .pin_port0      (pin_port0),
        .pin_port1      (pin_port1),
        .cpu_sleep      (cpu_sleep),
        .edge_int_req   (edge_int_req),
        .cpu_wake_req   (cpu_wake_req),
        .edge_int_out   (edge_int_out),
        .rise_wake_flag (rise_wake_flag),
        .fall_wake_flag (fall_wake_flag)
    );

    gfw_pin_src u_src (
        .clk_sys   (clk_sys),
        .pin_port0 (pin_port0),
        .pin_port1 (pin_port1)
    );

    task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_done();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        reg_read(`GFW_CFG_ADDR, 8'h00);
        reg_write(16'hA02F, 8'hFF);
        reg_read(16'hA02F, 8'h00);
        reg_read(`GFW_CFG_ADDR, 8'h00);
        @(posedge clk_sys);
        cpu_sleep <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            en   = 2'((k % 3) + 1);
            code = 2'(k % 4);
            n    = BASE << code;
            reg_write(`GFW_CFG_ADDR, {en, code, 4'(k)});
            u_src.pulse(k ^ 1, 1'b1, 3 * n);
            u_src.pulse(k, 1'b1, n - 1);
            settle(n + 8);
            `CHK({rise_wake_flag, fall_wake_flag, cpu_wake_req}, 3'b000)
            u_src.set_pin(k, 1'b1);
            settle(n);
            `CHK({rise_wake_flag, fall_wake_flag}, 2'b00)
            settle(8);
            `CHK({rise_wake_flag, fall_wake_flag, cpu_wake_req}, {en[1], 1'b0, en[1]})
            reg_read(`GFW_CFG_ADDR, {en[1], 1'b0, code, 4'(k)});
            u_src.set_pin(k, 1'b0);
            settle(n + 8);
            `CHK({rise_wake_flag, fall_wake_flag, cpu_wake_req}, {en, 1'b1})
            @(posedge clk_sys);
            cpu_sleep <= 1'b0;
            settle(2);
            `CHK(cpu_wake_req, 1'b0)
            reg_write(`GFW_CFG_ADDR, {2'b00, code, 4'(k)});
            reg_read(`GFW_CFG_ADDR, {2'b00, code, 4'(k)});
            @(posedge clk_sys);
            cpu_sleep <= 1'b1;
        end
        @(posedge clk_sys);
        edge_int_req <= 1'b1;
        @(posedge clk_sys);
        edge_int_req <= 1'b0;
        #1 `CHK({cpu_wake_req, edge_int_out}, 2'b11)
        settle(1);
        `CHK(edge_int_out, 1'b0)
        reg_write(`GFW_CFG_ADDR, 8'hC5);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        reg_read(`GFW_CFG_ADDR, 8'h00);
        `CHK({cpu_wake_req, rise_wake_flag, fall_wake_flag}, 3'b000)
        test_done();
    end
endmodule
`default_nettype wire
